//--- logic/cc_pkg.sv
package cc_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_PCAB = 8'h00;
   localparam logic [7:0] OFF_PCCD = 8'h04;
   localparam logic [7:0] OFF_CNT  = 8'h08;
   localparam logic [7:0] OFF_GRA  = 8'h0c;
   localparam logic [7:0] OFF_GRB  = 8'h10;
   localparam logic [7:0] OFF_GRC  = 8'h14;
   localparam logic [7:0] OFF_GRD  = 8'h18;
   localparam logic [7:0] OFF_MODE = 8'h1c;
   localparam logic [7:0] OFF_CTRL = 8'h20;
   localparam logic [7:0] OFF_IER  = 8'h24;
   localparam logic [7:0] OFF_STAT = 8'h28;

   // ----------------------------------------
   // Field positions and masks
   // ----------------------------------------
   localparam int         FUNC_LO   = 2;
   localparam int         FUNC_HI   = 6;
   localparam int         ACT_LO    = 0;
   localparam int         ACT_HI    = 4;
   localparam logic [7:0] PC_RSV    = 8'h88;
   localparam logic [7:0] PC_WR     = 8'h77;
   localparam int         BUFA_BIT  = 4;
   localparam int         BUFB_BIT  = 5;
   localparam int         COUNTER_CLEAR_ENABLE_BIT  = 7;
   localparam int         OVERFLOW_IRQ_ENABLE_BIT  = 7;
   localparam int         OVF_BIT   = 7;
   localparam logic [7:0] STAT_RSV  = 8'h70;
   localparam logic [7:0] MODE_WR   = 8'h30;
   localparam logic [7:0] CTRL_WR   = 8'h87;
   localparam logic [7:0] IER_WR    = 8'h8f;
   localparam logic [7:0] STAT_WR   = 8'h8f;
   localparam int         CKS_W     = 3;

   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [15:0] CNT_MAX  = 16'hffff;
   localparam logic [15:0] GR_RST   = 16'hffff;
   localparam logic [1:0]  ACT_NONE = 2'h0;
   localparam logic [1:0]  ACT_LOW  = 2'h1;
   localparam logic [1:0]  ACT_HIGH = 2'h2;
   localparam logic [1:0]  ACT_TGL  = 2'h3;
   localparam int          BOTH_BIT = 1;
   localparam int          FALL_BIT = 0;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } cc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } cc_apb_rsp_t;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe_n;
   } cc_pin_t;

   typedef struct packed {
      logic       ovf;
      logic [3:0] chan;
   } cc_irq_t;

   typedef struct packed {
      logic [15:0]      cnt;
      logic [7:0]       pre;
      logic [3:0][15:0] gr;
      logic [7:0]       pcab;
      logic [7:0]       pccd;
      logic [7:0]       mode;
      logic [7:0]       ctrl;
      logic [7:0]       ier;
      logic [7:0]       flags;
      logic [7:0]       armed;
      logic [3:0]       sync1;
      logic [3:0]       sync2;
      logic [3:0]       sync3;
      cc_pin_t          pin;
      cc_irq_t          irq;
      cc_apb_rsp_t      rsp;
   } cc_state_t;

endpackage : cc_pkg

//--- logic/cc_timer.sv
// Notes on behaviour
// - First control byte: bit6 B, bit2 A capture
// - Second control byte: bit6 D, bit2 C capture
// - Compare action: none, low, high, toggle
// - Capture edge: rising, falling, or both
// - Reserved bits 7,3 read one; others reset zero
// - 16-bit counter, clock from three-bit select
// - Clear enable zeroes counter on A match
// - Wrap sets overflow flag, interrupt if enabled
// - Counter resets to zero
// - General registers reset to all ones
// - Compare mode match sets channel flag
// - Enabled flag raises channel interrupt request
// - Capture edge loads counter, sets flag
// - C buffers A, D buffers B when enabled
// - Buffered compare: buffer to primary on match
// - Buffered capture: primary to buffer, counter in
// - Match fires when counter leaves matching value
// - Pin at selected level stays unchanged
// - Flag clears by write zero after reading one
module cc_timer (
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           ce,
   input  wire cc_pkg::cc_apb_req_t apb_req,
   output cc_pkg::cc_apb_rsp_t apb_rsp,
   input  wire logic [3:0]     pin_in,
   output cc_pkg::cc_pin_t     pin,
   output cc_pkg::cc_irq_t     irq
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   cc_pkg::cc_state_t st;
   cc_pkg::cc_state_t next_st;

   logic       tick;
   logic [7:0] pre_mask;
   logic [3:0] func;
   logic [3:0][1:0] act;
   logic [3:0] match;
   logic [3:0] rise;
   logic [3:0] fall;
   logic [3:0] cap;
   logic       clr_a;
   logic       wr_en;
   logic       rd_en;
   logic       setup;
   logic [31:0] rd_val;
   logic       rd_hit;

   assign apb_rsp = st.rsp;
   assign pin     = st.pin;
   assign irq     = st.irq;

   // ----------------------------------------
   // Count clock
   // ----------------------------------------
   // Select n counts every 2**n pclk cycles
   assign pre_mask = 8'((9'h1 << st.ctrl[cc_pkg::CKS_W-1:0]) - 9'h1);
   assign tick     = ((st.pre & pre_mask) == pre_mask);

   // ----------------------------------------
   // Per-channel events
   // ----------------------------------------
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_ch
         localparam int F = (k % 2 == 1) ? cc_pkg::FUNC_HI : cc_pkg::FUNC_LO;
         localparam int A = (k % 2 == 1) ? cc_pkg::ACT_HI : cc_pkg::ACT_LO;
         logic [7:0] pc;
         assign pc = (k < 2) ? st.pcab : st.pccd;
         assign func[k] = pc[F];
         assign act[k]  = pc[A+1:A];
         // Event sits on the edge that moves the count off the value
         assign match[k] = !func[k] && tick && (st.cnt == st.gr[k]);
         // Second and third stages only; first stage stays private
         assign rise[k] = st.sync2[k] && !st.sync3[k];
         assign fall[k] = !st.sync2[k] && st.sync3[k];
         assign cap[k]  = func[k] && (act[k][cc_pkg::BOTH_BIT] ? (rise[k] || fall[k]) :
                          act[k][cc_pkg::FALL_BIT] ? fall[k] : rise[k]);
      end
   endgenerate

   assign clr_a = match[0] && st.ctrl[cc_pkg::COUNTER_CLEAR_ENABLE_BIT];

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign setup = apb_req.psel && !apb_req.penable;
   assign wr_en = apb_req.psel && apb_req.penable && st.rsp.pready && apb_req.pwrite;
   assign rd_en = apb_req.psel && apb_req.penable && st.rsp.pready && !apb_req.pwrite;

   always_comb begin
      rd_val = 32'h0;
      rd_hit = 1'b1;
      unique case (apb_req.paddr)
         cc_pkg::OFF_PCAB: rd_val = {24'h0, st.pcab | cc_pkg::PC_RSV};
         cc_pkg::OFF_PCCD: rd_val = {24'h0, st.pccd | cc_pkg::PC_RSV};
         cc_pkg::OFF_CNT:  rd_val = {16'h0, st.cnt};
         cc_pkg::OFF_GRA:  rd_val = {16'h0, st.gr[0]};
         cc_pkg::OFF_GRB:  rd_val = {16'h0, st.gr[1]};
         cc_pkg::OFF_GRC:  rd_val = {16'h0, st.gr[2]};
         cc_pkg::OFF_GRD:  rd_val = {16'h0, st.gr[3]};
         cc_pkg::OFF_MODE: rd_val = {24'h0, st.mode};
         cc_pkg::OFF_CTRL: rd_val = {24'h0, st.ctrl};
         cc_pkg::OFF_IER:  rd_val = {24'h0, st.ier};
         cc_pkg::OFF_STAT: rd_val = {24'h0, st.flags | cc_pkg::STAT_RSV};
         default:          rd_hit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [7:0] ev;
      logic [7:0] wd;
      ev      = 8'h0;
      wd      = apb_req.pwdata[7:0];
      next_st = st;

      // Synchronisers
      next_st.sync1 = pin_in;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;

      // Counter
      next_st.pre = st.pre + 8'h1;
      if (tick) begin
         next_st.cnt = clr_a ? cc_pkg::CNT_RST : st.cnt + 16'h1;
      end
      ev[cc_pkg::OVF_BIT] = tick && !clr_a && (st.cnt == cc_pkg::CNT_MAX);
      ev[3:0] = match | cap;

      // Pin actions and captures
      for (int i = 0; i < 4; i++) begin
         next_st.pin.oe_n[i] = func[i];
         if (match[i]) begin
            unique case (act[i])
               cc_pkg::ACT_NONE: next_st.pin.out[i] = st.pin.out[i];
               cc_pkg::ACT_LOW:  next_st.pin.out[i] = 1'b0;
               cc_pkg::ACT_HIGH: next_st.pin.out[i] = 1'b1;
               cc_pkg::ACT_TGL:  next_st.pin.out[i] = !st.pin.out[i];
            endcase
         end
         if (cap[i]) begin
            next_st.gr[i] = st.cnt;
         end
      end

      // Buffer pairs: A with C, B with D
      for (int i = 0; i < 2; i++) begin
         if (st.mode[cc_pkg::BUFA_BIT + i]) begin
            if (match[i]) begin
               next_st.gr[i] = st.gr[i+2];
            end
            if (cap[i]) begin
               next_st.gr[i+2] = st.gr[i];
            end
         end
      end

      // Bus response, one access cycle per transfer
      next_st.rsp.pready = setup;
      if (setup) begin
         next_st.rsp.prdata  = apb_req.pwrite ? 32'h0 : rd_val;
         next_st.rsp.pslverr = !rd_hit;
      end

      // Reading a one arms that flag for a later clear
      if (rd_en && apb_req.paddr == cc_pkg::OFF_STAT) begin
         next_st.armed = st.armed | (st.rsp.prdata[7:0] & cc_pkg::STAT_WR);
      end

      // Software writes; data writes win over hardware loads
      if (wr_en) begin
         unique case (apb_req.paddr)
            cc_pkg::OFF_PCAB: next_st.pcab = wd & cc_pkg::PC_WR;
            cc_pkg::OFF_PCCD: next_st.pccd = wd & cc_pkg::PC_WR;
            cc_pkg::OFF_CNT:  next_st.cnt = apb_req.pwdata[15:0];
            cc_pkg::OFF_GRA:  next_st.gr[0] = apb_req.pwdata[15:0];
            cc_pkg::OFF_GRB:  next_st.gr[1] = apb_req.pwdata[15:0];
            cc_pkg::OFF_GRC:  next_st.gr[2] = apb_req.pwdata[15:0];
            cc_pkg::OFF_GRD:  next_st.gr[3] = apb_req.pwdata[15:0];
            cc_pkg::OFF_MODE: next_st.mode = wd & cc_pkg::MODE_WR;
            cc_pkg::OFF_CTRL: next_st.ctrl = wd & cc_pkg::CTRL_WR;
            cc_pkg::OFF_IER:  next_st.ier = wd & cc_pkg::IER_WR;
            cc_pkg::OFF_STAT: begin
               // Write zero clears only armed bits; writing one does nothing
               next_st.flags = st.flags & ~(st.armed & ~wd);
               next_st.armed = 8'h0;
            end
            default: ;
         endcase
      end

      // Hardware set wins over a clear in the same cycle
      next_st.flags = next_st.flags | ev;

      next_st.irq.ovf  = st.flags[cc_pkg::OVF_BIT] && st.ier[cc_pkg::OVERFLOW_IRQ_ENABLE_BIT];
      next_st.irq.chan = st.flags[3:0] & st.ier[3:0];
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st          <= '0;
         st.cnt      <= cc_pkg::CNT_RST;
         st.gr       <= {4{cc_pkg::GR_RST}};
         st.pin.oe_n <= 4'h0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence rise_held_s;
      (ce && !pin_in[1]) ##1 (ce && pin_in[1]) [*3];
   endsequence

   sequence read_pc_s;
      rd_en && apb_req.paddr == cc_pkg::OFF_PCAB;
   endsequence

   reserved_read_a: assert property (read_pc_s |-> apb_rsp.prdata[7] && apb_rsp.prdata[3])
      else $error("reserved bits did not read one");

   ovf_set_a: assert property (ce && tick && !clr_a && !wr_en && st.cnt == cc_pkg::CNT_MAX
      |=> st.flags[cc_pkg::OVF_BIT] && st.cnt == cc_pkg::CNT_RST)
      else $error("overflow flag not set on wrap");

   period_clear_a: assert property (ce && clr_a && !wr_en |=> st.cnt == cc_pkg::CNT_RST)
      else $error("counter not cleared on match A");

   match_flag_a: assert property (ce && match[1] |=> st.flags[1])
      else $error("match did not set flag B");

   pin_high_a: assert property (ce && match[1] && act[1] == cc_pkg::ACT_HIGH
      |=> pin.out[1] ##1 (!ce || pin.out[1] || match[1]))
      else $error("pin B not driven high");

   cap_load_a: assert property (ce && cap[1] && !wr_en |=> st.gr[1] == $past(st.cnt))
      else $error("capture did not load counter");

   buf_cmp_a: assert property (ce && match[0] && st.mode[cc_pkg::BUFA_BIT] && !wr_en
      |=> st.gr[0] == $past(st.gr[2]))
      else $error("buffer not moved on match");

   buf_cap_a: assert property (ce && cap[0] && st.mode[cc_pkg::BUFA_BIT] && !wr_en
      |=> st.gr[2] == $past(st.gr[0]) && st.gr[0] == $past(st.cnt))
      else $error("capture buffer chain broken");

   flag_keep_a: assert property (ce && st.flags[0] && !st.armed[0] |=> st.flags[0])
      else $error("unarmed flag was cleared");

   irq_chan_a: assert property (ce && st.flags[2] && st.ier[2] |=> irq.chan[2])
      else $error("channel C request missing");

   edge_seen_a: assert property (rise_held_s ##0 (func[1] && act[1] == cc_pkg::ACT_NONE)
      |-> cap[1])
      else $error("rising edge not captured");

endmodule : cc_timer

//--- testbench/cc_pin_model.sv
// ----------------------------------------
// Far-side source for the four channel pins
// ----------------------------------------
module cc_pin_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] lvl_req,
   output logic [3:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // Levels move only on clock edges; the bench holds each for many cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_in <= 4'h0;
      end else begin
         pin_in <= lvl_req;
      end
   end
endmodule : cc_pin_model

//--- testbench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic                pclk = 1'b0;
   logic                presetn = 1'b0;
   logic [3:0]          lvl = 4'h0;
   logic [3:0]          ext;
   logic [3:0]          pin_w;
   cc_pkg::cc_apb_req_t req = '0;
   cc_pkg::cc_apb_rsp_t rsp;
   cc_pkg::cc_pin_t     pin;
   cc_pkg::cc_irq_t     irq;
   int                  err_count = 0;
   int                  checks_done = 0;
   int                  cyc = 0;
   logic [31:0]         v;
   logic                e;
   logic [1:0]          acts [5] = '{2'h2, 2'h2, 2'h1, 2'h3, 2'h0};
   logic                exps [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic [7:0]          pcs [3] = '{8'h44, 8'h45, 8'h46};
   logic [15:0]         cnts [3] = '{16'h1234, 16'h5678, 16'h2222};
   logic                lvls [3] = '{1'b1, 1'b0, 1'b1};

   always #4 pclk = ~pclk;

   // Wire level: design drives when its enable is low
   assign pin_w = (~pin.oe_n & pin.out) | (pin.oe_n & ext);

   cc_timer u_dut (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (1'b1),
      .apb_req (req),
      .apb_rsp (rsp),
      .pin_in  (pin_w),
      .pin     (pin),
      .irq     (irq)
   );

   cc_pin_model u_pins (
      .pclk    (pclk),
      .presetn (presetn),
      .lvl_req (lvl),
      .pin_in  (ext)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
      checks_done++;
      if (got !== x) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, x, got);
      end
   endtask : chk

   // Answer is taken at the edge where pready is seen high, then released
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      v = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, x, v & m);
   endtask : rd

   task automatic waitc(input int n);
      repeat (n) @(negedge pclk);
   endtask : waitc

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out

   // Whole run needs about 600 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd("port_ctrl_ab", 8'h00, 32'hff, 32'h88);
      rd("port_ctrl_cd", 8'h04, 32'hff, 32'h88);
      for (int i = 0; i < 4; i++) begin
         rd("general_reg", 8'h0c + 8'(4 * i), 32'hffffffff, 32'hffff);
      end
      wr(8'h00, 32'h77);
      rd("port_ctrl_ab", 8'h00, 32'hffffffff, 32'hff);
      $display("reset and access test done");
      for (int i = 0; i < 5; i++) begin
         wr(8'h00, 32'(acts[i]));
         wr(8'h0c, 32'h20);
         wr(8'h08, 32'h0);
         waitc(48);
         chk("pin_a", 32'(exps[i]), 32'(pin.out[0]));
      end
      chk("oe_a", 32'h0, 32'(pin.oe_n[0]));
      rd("status_a", 8'h28, 32'h01, 32'h01);
      wr(8'h24, 32'h01);
      waitc(3);
      chk("irq_a", 32'h1, 32'(irq.chan[0]));
      $display("compare test done");
      // Channel B sets high when the wrap passes its reset compare value
      wr(8'h00, 32'h20);
      wr(8'h08, 32'hfff0);
      waitc(32);
      chk("pin_b", 32'h1, 32'(pin.out[1]));
      rd("status_ovf", 8'h28, 32'h80, 32'h80);
      wr(8'h24, 32'h85);
      waitc(3);
      chk("irq_ovf", 32'h1, 32'(irq.ovf));
      wr(8'h28, 32'h7f);
      rd("status_clr", 8'h28, 32'h81, 32'h01);
      wr(8'h20, 32'h80);
      wr(8'h0c, 32'h10);
      wr(8'h08, 32'h0);
      waitc(40);
      apb(1'b0, 8'h08, 32'h0);
      chk("cnt_period", 32'h1, 32'(v <= 32'h10));
      $display("counter test done");
      wr(8'h20, 32'h0);
      wr(8'h1c, 32'h10);
      wr(8'h14, 32'h99);
      wr(8'h0c, 32'h40);
      wr(8'h08, 32'h0);
      waitc(80);
      rd("buf_cmp", 8'h0c, 32'hffff, 32'h99);
      // Slow count so a capture lands at most one tick after the write
      wr(8'h20, 32'h07);
      for (int i = 0; i < 3; i++) begin
         wr(8'h00, 32'(pcs[i]));
         wr(8'h08, 32'(cnts[i]));
         @(posedge pclk);
         lvl[0] <= lvls[i];
         lvl[1] <= lvls[i];
         waitc(8);
         rd("cap_a", 8'h0c, 32'hfffe, 32'(cnts[i]));
         if (i > 0) begin
            rd("cap_buf", 8'h14, 32'hfffe, 32'(cnts[i - 1]));
         end
      end
      chk("oe_a_cap", 32'h1, 32'(pin.oe_n[0]));
      wr(8'h04, 32'h44);
      rd("port_ctrl_cd", 8'h04, 32'hff, 32'hcc);
      waitc(2);
      chk("oe_cd_cap", 32'h3, 32'(pin.oe_n[3:2]));
      apb(1'b0, 8'h2c, 32'h0);
      chk("bad_addr", 32'h1, 32'(e));
      $display("capture test done");
      close_out();
   end
endmodule : tb_top
